/* hdl/dis_consts.svh */
// Summary of operation
// - The two mode-select pins choose CRC/direct (00), plain/direct (01), CRC/chain (10), plain/chain (11).
// - CRC frames carry three fill bits and a 5-bit CRC; the device answers supply-low, supply-missing, zero, CRC.
// - The first output byte of every frame is the input snapshot, channel 8 first.
// - Direct modes return the addressed register in byte two of a read frame and zeros for a write.
// - Chain modes return zeros in byte two when the previous frame was a write or a null command.
// - Chain modes return the previous read's data in byte two whatever the current command is.
// - The input snapshot is frozen when chip select falls, or when the snapshot strobe falls outside a frame.
// - The supply flags are frozen by the chip select fall only, never by the strobe.
// - The supply flags sent are the synchronised supply-low and supply-missing input pins.
// - In the plain modes a frame of exactly eight clocks is accepted and fetches the snapshot only.
// - An eight-clock plain frame does no register access; in plain/direct it still loads reg_addr_out from its first byte.
// - The device computes a CRC over the bits it shifts out and sends it at the frame end.
// - A null command changes no register and may pad or flush a chain.
// - Serial input is sampled on rising clock edges and the output changes on falling edges.
// - Clock pulses are counted per frame; a count below 248 that is not a multiple of 8 drops the frame and flags an error.
`ifndef DIS_CONSTS_SVH
`define DIS_CONSTS_SVH
`define DIS_LEN_PLAIN 8'h10
`define DIS_LEN_CRC 8'h18
`define DIS_LEN_SHORT 8'h08
`define DIS_POS_FLAG_LOW 8'h10
`define DIS_POS_FLAG_MISS 8'h11
`define DIS_POS_FILL_ZERO 8'h12
`define DIS_POS_CRC_FIRST 8'h13
`define DIS_POS_CRC_LAST 8'h17
`define DIS_NULL_ADDR 7'h26
`define DIS_CRC_POLY 5'h05
`define DIS_CRC_SEED 5'h1F
`endif

/* hdl/dis_pkg.sv */
package dis_pkg;
  typedef enum logic [1:0] {
    DIS_IDLE = 2'b01,
    DIS_SHIFT = 2'b10
  } dis_frame_e;
  typedef logic [4:0] dis_crc_t;
endpackage : dis_pkg

/* hdl/dis_spi_frame.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dis_consts.svh"
module dis_spi_frame (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_b_in,
  input wire logic sdi_in,
  input wire logic snap_b_in,
  input wire logic mode_select_low_in,
  input wire logic mode_select_high_in,
  input wire logic [7:0] field_input_channels_in,
  input wire logic field_supply_low_flag_in,
  input wire logic field_supply_missing_flag_in,
  input wire logic [7:0] reg_rd_data_in,
  output logic sdo_out,
  output logic sdo_oe_b_out,
  output logic [6:0] reg_addr_out,
  output logic reg_rd_en_out,
  output logic reg_wr_en_out,
  output logic [7:0] reg_wr_data_out,
  output logic clock_count_error_out
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [1:0] sclk_s, cs_s, sdi_s, snap_s, msl_s, msh_s, fl_s, fm_s;
  logic [7:0] fin_s1, fin_s2;
  logic sclk_d, cs_d, snap_d;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sclk_s <= 2'h0;
      cs_s <= 2'h3;
      sdi_s <= 2'h0;
      snap_s <= 2'h3;
      msl_s <= 2'h0;
      msh_s <= 2'h0;
      fl_s <= 2'h0;
      fm_s <= 2'h0;
      fin_s1 <= 8'h00;
      fin_s2 <= 8'h00;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      snap_d <= 1'b1;
    end else if (ce_in) begin
      sclk_s <= {sclk_s[0], sclk_in};
      cs_s <= {cs_s[0], cs_b_in};
      sdi_s <= {sdi_s[0], sdi_in};
      snap_s <= {snap_s[0], snap_b_in};
      msl_s <= {msl_s[0], mode_select_low_in};
      msh_s <= {msh_s[0], mode_select_high_in};
      fl_s <= {fl_s[0], field_supply_low_flag_in};
      fm_s <= {fm_s[0], field_supply_missing_flag_in};
      fin_s1 <= field_input_channels_in;
      fin_s2 <= fin_s1;
      sclk_d <= sclk_s[1];
      cs_d <= cs_s[1];
      snap_d <= snap_s[1];
    end
  end

  // ==========================================================
  // decode
  // ==========================================================
  dis_pkg::dis_frame_e state_r, state_nxt;
  logic [7:0] cnt_r, snap_r, byte2_r, held_r;
  logic [23:0] rx_r;
  logic flag_low_r, flag_miss_r, prev_read_r, b2_pend_r, end_pend_r, end_read_r, end_write_r;
  dis_pkg::dis_crc_t crc_r;
  wire crc_en = ~msl_s[1];
  wire daisy = msh_s[1];
  wire cs_fall = cs_d & ~cs_s[1];
  wire cs_rise = ~cs_d & cs_s[1];
  wire snap_fall = snap_d & ~snap_s[1];
  wire in_frame = (state_r == dis_pkg::DIS_SHIFT);
  wire sclk_rise = in_frame & ~sclk_d & sclk_s[1];
  wire sclk_fall = in_frame & sclk_d & ~sclk_s[1];
  wire [7:0] frame_len = crc_en ? `DIS_LEN_CRC : `DIS_LEN_PLAIN;
  wire [23:0] rx_nxt = {rx_r[22:0], sdi_s[1]};
  // command fields, first bit is read/write
  wire cmd_write = crc_en ? rx_r[23] : rx_r[15];
  wire [6:0] cmd_addr = crc_en ? rx_r[22:16] : rx_r[14:8];
  wire [7:0] cmd_data = crc_en ? rx_r[15:8] : rx_r[7:0];
  wire cnt_bad = (cnt_r[2:0] != 3'h0);
  // short plain frame carries no command
  wire short_plain = ~crc_en & (cnt_r == `DIS_LEN_SHORT);
  wire frame_ok = cs_rise & ~cnt_bad & ~short_plain & (cnt_r >= frame_len);
  wire cmd_null = cmd_write & (cmd_addr == `DIS_NULL_ADDR);
  // strobe fall captures, strobe held low keeps that capture
  wire [7:0] snap_src = (snap_s[1] | snap_fall) ? fin_s2 : snap_r;
  // serial crc step over the bit leaving the pin
  wire crc_fb = crc_r[4] ^ sdo_out;
  wire [4:0] crc_upd = {crc_r[3:0], 1'b0} ^ (crc_fb ? `DIS_CRC_POLY : 5'h00);
  wire crc_take = (cnt_r != 8'h00) & (cnt_r <= `DIS_POS_CRC_FIRST);
  wire [7:0] crc_sel = `DIS_POS_CRC_LAST - cnt_r;
  wire [7:0] b1_sel = 8'h07 - cnt_r;
  wire [7:0] b2_sel = 8'h0F - cnt_r;
  wire tail_bit = (cnt_r == `DIS_POS_FLAG_LOW) ? flag_low_r :
                  (cnt_r == `DIS_POS_FLAG_MISS) ? flag_miss_r :
                  (cnt_r == `DIS_POS_FILL_ZERO) ? 1'b0 :
                  (cnt_r == `DIS_POS_CRC_FIRST) ? crc_upd[4] : crc_r[crc_sel[2:0]];
  // byte one then msb first through every field
  wire own_bit = (cnt_r < 8'h08) ? snap_r[b1_sel[2:0]] :
                 (cnt_r < 8'h10) ? byte2_r[b2_sel[2:0]] : tail_bit;
  // chained devices pass on what they received one frame earlier
  wire pass_bit = crc_en ? rx_r[23] : rx_r[15];
  wire next_bit = (cnt_r >= frame_len) ? (daisy ? pass_bit : 1'b0) : own_bit;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dis_pkg::DIS_IDLE: if (cs_fall) state_nxt = dis_pkg::DIS_SHIFT;
      dis_pkg::DIS_SHIFT: if (cs_rise) state_nxt = dis_pkg::DIS_IDLE;
    endcase
  end

  // ==========================================================
  // frame state
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= dis_pkg::DIS_IDLE;
      cnt_r <= 8'h00;
      rx_r <= 24'h000000;
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (cs_fall) begin
        cnt_r <= 8'h00;
      end else if (sclk_rise) begin
        // saturate at a legal length so very long chains cannot wrap to a short count
        cnt_r <= (cnt_r == 8'hF8) ? 8'hF8 : cnt_r + 8'h01;
        rx_r <= rx_nxt;
      end
    end
  end

  // ==========================================================
  // snapshot and flags
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      snap_r <= 8'h00;
      flag_low_r <= 1'b0;
      flag_miss_r <= 1'b0;
    end else if (ce_in) begin
      if (cs_fall | (snap_fall & ~in_frame)) snap_r <= snap_src;
      // flags frozen by chip select only
      if (cs_fall) begin
        flag_low_r <= fl_s[1];
        flag_miss_r <= fm_s[1];
      end
    end
  end

  // ==========================================================
  // serial output
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sdo_out <= 1'b0;
      sdo_oe_b_out <= 1'b1;
      crc_r <= `DIS_CRC_SEED;
    end else if (ce_in) begin
      sdo_oe_b_out <= ~(in_frame | cs_fall);
      if (cs_fall) begin
        sdo_out <= snap_src[7];
        crc_r <= `DIS_CRC_SEED;
      end else if (sclk_fall) begin
        // output moves on the falling edge
        sdo_out <= next_bit;
        if (crc_take) crc_r <= crc_upd;
      end
    end
  end

  // ==========================================================
  // second byte and register access
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      byte2_r <= 8'h00;
      held_r <= 8'h00;
      prev_read_r <= 1'b0;
      b2_pend_r <= 1'b0;
      end_pend_r <= 1'b0;
      end_read_r <= 1'b0;
      end_write_r <= 1'b0;
      reg_addr_out <= 7'h00;
      reg_wr_data_out <= 8'h00;
      reg_rd_en_out <= 1'b0;
      reg_wr_en_out <= 1'b0;
      clock_count_error_out <= 1'b0;
    end else if (ce_in) begin
      b2_pend_r <= 1'b0;
      end_pend_r <= 1'b0;
      reg_rd_en_out <= end_pend_r & end_read_r;
      reg_wr_en_out <= end_pend_r & end_write_r;
      // error pulse on a bad count
      clock_count_error_out <= cs_rise & cnt_bad;
      if (cs_fall) begin
        // chain byte two from the previous frame
        byte2_r <= (daisy & prev_read_r) ? held_r : 8'h00;
      end
      // direct read decoded on the fly, writes keep zeros
      if (sclk_rise & ~daisy & (cnt_r == 8'h07)) begin
        reg_addr_out <= rx_nxt[6:0];
        b2_pend_r <= ~rx_nxt[7];
      end
      if (b2_pend_r) byte2_r <= reg_rd_data_in;
      if (frame_ok) begin
        reg_addr_out <= cmd_addr;
        reg_wr_data_out <= cmd_data;
        end_pend_r <= 1'b1;
        end_read_r <= ~cmd_write;
        // null commands never reach the register file
        end_write_r <= cmd_write & ~cmd_null;
        prev_read_r <= ~cmd_write;
      end
      // keep read data for the next chain frame
      if (end_pend_r & end_read_r) held_r <= reg_rd_data_in;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_short_no_access: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & cs_rise & short_plain) |-> ##1 !end_pend_r ##1 !reg_wr_en_out && !reg_rd_en_out)
    else $error("short frame caused a register access");
  a_count_error: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & cs_rise & cnt_bad) |=> clock_count_error_out ##1 !reg_wr_en_out)
    else $error("bad clock count not flagged or not discarded");
  a_null_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    reg_wr_en_out |-> (reg_addr_out != `DIS_NULL_ADDR))
    else $error("null command wrote a register");
  a_chain_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & cs_fall & daisy & !prev_read_r) |=> (byte2_r == 8'h00))
    else $error("chain byte two not zero after write");
  a_chain_data: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & cs_fall & daisy & prev_read_r) |=> (byte2_r == $past(held_r)))
    else $error("chain byte two lost previous read data");
  a_first_bit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & cs_fall) |=> (sdo_out == snap_r[7]) && !sdo_oe_b_out)
    else $error("first output bit is not channel 8 snapshot");
  a_flags_frozen: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (in_frame && $past(in_frame) && !$past(cs_fall)) |-> $stable(flag_low_r) && $stable(flag_miss_r))
    else $error("supply flags changed inside a frame");
  a_snap_frozen: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (in_frame && $past(in_frame) && !$past(cs_fall)) |-> $stable(snap_r))
    else $error("snapshot changed inside a frame");
  a_fill_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & sclk_fall & crc_en & (cnt_r == `DIS_POS_FILL_ZERO)) |=> !sdo_out)
    else $error("crc frame fill bit not zero");
  a_direct_read: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ce_in & b2_pend_r) |=> (byte2_r == $past(reg_rd_data_in)))
    else $error("direct read data not loaded into byte two");
endmodule : dis_spi_frame
`default_nettype wire

/* bench/dis_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dis_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic cs_b_out,
  output logic sdi_out
);
  // ==========================================
  // spi mode 0 host, clock idles low
  initial begin
    sclk_out = 1'b0;
    cs_b_out = 1'b1;
    sdi_out = 1'b0;
  end
  // sdo is read late in the high half, well after the device's fall update
  // msb first, sdi moves on the fall
  task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h000000;
    @(posedge clk_in);
    #1;
    cs_b_out = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      sdi_out = tx[23 - i];
      #400;
      sclk_out = 1'b1;
      #380;
      rx[23 - i] = sdo_in;
      #20;
      sclk_out = 1'b0;
    end
    #400;
    cs_b_out = 1'b1;
    // released line shows the inverse of its last level
    sdi_out = ~sdi_out;
    #800;
  endtask : xfer
endmodule : dis_host
`default_nettype wire

/* bench/dis_spi_frame_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dis_consts.svh"
module dis_spi_frame_tb;
  logic clk_in, rst_b_in, snap_b, m_lo, m_hi, f_low, f_miss;
  logic [7:0] field;
  logic [7:0] rd_data;
  logic [23:0] rx;
  logic [15:0] p;
  logic [15:0] ch [6] = '{16'h A600, 16'h3300, 16'h8711, 16'hA600, 16'h4400, 16'hA600};
  logic [6:0] wa = 7'h00;
  logic [7:0] wd = 8'h00;
  wire logic sclk, cs_b, sdi, sdo, oe_b, rd_en, wr_en, cnt_err;
  wire logic [6:0] addr;
  wire logic [7:0] wr_data;
  int failures = 0, tests_run = 0, n_rd = 0, n_wr = 0, n_err = 0;
  // ==========================================
  // design, host and register file stand-in
  dis_spi_frame dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1), .sclk_in(sclk),
    .cs_b_in(cs_b), .sdi_in(sdi), .snap_b_in(snap_b), .mode_select_low_in(m_lo),
    .mode_select_high_in(m_hi), .field_input_channels_in(field),
    .field_supply_low_flag_in(f_low), .field_supply_missing_flag_in(f_miss),
    .reg_rd_data_in(rd_data), .sdo_out(sdo), .sdo_oe_b_out(oe_b), .reg_addr_out(addr),
    .reg_rd_en_out(rd_en), .reg_wr_en_out(wr_en), .reg_wr_data_out(wr_data),
    .clock_count_error_out(cnt_err));
  dis_host host_u (.clk_in(clk_in), .sdo_in(sdo), .sclk_out(sclk), .cs_b_out(cs_b),
    .sdi_out(sdi));
  function automatic logic [7:0] rdv(input logic [6:0] a);
    return {1'b0, a} ^ 8'hA5;
  endfunction : rdv
  // expected crc frame: bits 23..5 as given, crc over them from the seed, msb first
  function automatic logic [23:0] with_crc(input logic [23:0] w);
    logic [4:0] c;
    c = `DIS_CRC_SEED;
    for (int i = 23; i > 4; i--) begin
      c = {c[3:0], 1'b0} ^ ((c[4] ^ w[i]) ? `DIS_CRC_POLY : 5'h00);
    end
    return {w[23:5], c};
  endfunction : with_crc
  assign rd_data = rdv(addr);
  always @(posedge clk_in) begin
    n_rd <= n_rd + int'(rd_en === 1'b1);
    n_err <= n_err + int'(cnt_err === 1'b1);
    if (wr_en === 1'b1) begin
      n_wr <= n_wr + 1;
      wa <= addr;
      wd <= wr_data;
    end
  end
  // ==========================================
  // shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic drive(input logic [1:0] m, input logic s, input logic [9:0] fv);
    @(posedge clk_in);
    #1;
    {m_hi, m_lo} = m;
    snap_b = s;
    {field, f_low, f_miss} = fv;
    repeat (5) @(posedge clk_in);
  endtask : drive
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ==========================================
  // clock, watchdog, sequence
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    rst_b_in = 1'b0;
    {m_hi, m_lo, snap_b, field, f_low, f_miss} = {2'b01, 1'b1, 8'hC3, 2'b10};
    repeat (2) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    repeat (3) @(posedge clk_in);
    host_u.xfer(16, 24'h120000, rx);
    check(rx, {8'hC3, rdv(7'h12), 8'h00}, "direct read frame");
    host_u.xfer(16, 24'h855A00, rx);
    check(rx, 24'hC30000, "direct write frame");
    host_u.xfer(8, 24'h85FF00, rx);
    check(rx, 24'hC30000, "short frame");
    check({23'h000000, oe_b}, 24'h000001, "output released after frame");
    host_u.xfer(12, 24'h85FF00, rx);
    check({n_rd[7:0], n_wr[7:0], n_err[7:0]}, 24'h010101, "strobe counts");
    check({wa, wd}, {7'h05, 8'h5A}, "write address and data");
    drive(2'b11, 1'b1, {8'hC3, 2'b10});
    // chain starts from a null so the history is known; nulls pad and flush
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(16, {ch[i], 8'h00}, rx);
      p = ch[(i + 5) % 6];
      if (i > 0) begin
        check(rx, {8'hC3, p[15] ? 8'h00 : rdv(p[14:8]), 8'h00}, "chain");
      end
    end
    check({n_rd[7:0], n_wr[7:0], 8'h00}, 24'h030200, "null no write");
    check({9'h000, wa, wd}, {9'h000, 7'h07, 8'h11}, "last write kept");
    drive(2'b00, 1'b1, {8'hC3, 2'b10});
    // host fill bits are zero, crc from host is not checked by the device
    host_u.xfer(24, 24'h893C00, rx);
    check(rx, with_crc(24'hC30080), "crc frame flags");
    // strobe freezes byte one at 5A; the flags still follow until chip select falls
    drive(2'b10, 1'b0, {8'h5A, 2'b10});
    drive(2'b10, 1'b0, {8'h18, 2'b01});
    host_u.xfer(24, 24'h020000, rx);
    check(rx, with_crc({8'h5A, 8'h00, 8'h40}), "strobe freeze");
    drive(2'b10, 1'b1, {8'h18, 2'b01});
    host_u.xfer(24, 24'h020000, rx);
    check(rx, with_crc({8'h18, rdv(7'h02), 8'h40}), "cs freeze");
    check({n_rd[7:0], n_wr[7:0], n_err[7:0]}, 24'h050301, "final counts");
    wrap_up();
  end
endmodule : dis_spi_frame_tb
`default_nettype wire
